// File: src/pbc_pkg.sv
// constants shared by the ternary burst codec and its beat fifo
package pbc_pkg;
  // burst geometry
  localparam int DIN_W = 11;
  localparam int CODE_W = 14;
  localparam int NENC = 23;
  localparam int LANES = 11;
  localparam int BEATS = 16;
  localparam int NSYM = 176;
  localparam int BURST_W = 2 * NSYM;
  localparam int BEAT_W = 2 * LANES;
  localparam int DATA_W = 256;
  localparam int CRC_W = 18;
  localparam int NCRC3 = 6;
  localparam int FIFO_WORDS = 32;
  localparam logic [3:0] LAST_BEAT = 4'hf;
  // symbol positions of the small codes inside the burst
  localparam int REM_POS = 161;
  localparam int CRC_POS = 163;
  localparam int SP_POS = 175;
  // internal symbol codes of the three line levels and the one illegal code
  localparam logic [1:0] SYM_NEG = 2'h0;
  localparam logic [1:0] SYM_ZERO = 2'h1;
  localparam logic [1:0] SYM_POS = 2'h3;
  localparam logic [1:0] SYM_BAD = 2'h2;
  // fixed table entries of the eleven-bit code
  localparam int NPAIR = 10;
  localparam logic [10:0] PAIR_IN [NPAIR] = '{11'h025, 11'h125, 11'h040, 11'h140,
    11'h0fc, 11'h1fc, 11'h0ff, 11'h1ff, 11'h027, 11'h127};
  localparam logic [13:0] PAIR_OUT [NPAIR] = '{14'h0510, 14'h1110, 14'h04c7, 14'h10c7,
    14'h07ff, 14'h13ff, 14'h007c, 14'h013c, 14'h040d, 14'h100d};
  // ternary value of each fixed word; that input moves to a spare code
  localparam logic [11:0] PAIR_ALT [NPAIR] = '{12'h14d, 12'h333, 12'h12e, 12'h314,
    12'h1e5, 12'h3cb, 12'h033, 12'h069, 12'h0fa, 12'h2e0};
  localparam logic [11:0] SPARE_BASE = 12'h800;
  localparam logic [11:0] SPARE_END = 12'h80a;
endpackage : pbc_pkg

// File: src/pbc_fifo.sv
// flip-flop fifo with valid/ready on both sides
`timescale 1ns/100ps
module pbc_fifo
  import pbc_pkg::*;
#(
  parameter int WIDTH = BEAT_W + 1,
  parameter int DEPTH = FIFO_WORDS
) (
  // clock, reset, enable
  input wire logic clk,
  input wire logic rstn,
  input wire logic ce,
  // fill side
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  // drain side
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [AW-1:0] wptr_q;
  logic [AW-1:0] rptr_q;
  logic [AW:0] cnt_q;
  logic push;
  logic pop;

  // honest full and empty from the fill count
  assign in_ready = (cnt_q != (AW+1)'(DEPTH));
  assign out_valid = (cnt_q != '0);
  assign push = in_valid && in_ready && ce;
  assign pop = out_valid && out_ready && ce;
  assign out_data = mem_q[rptr_q];

  // storage
  always_ff @(posedge clk) begin
    if (push) begin
      mem_q[wptr_q] <= in_data;
    end
  end

  // pointers and count
  always_ff @(posedge clk) begin
    if (!rstn) begin
      wptr_q <= '0;
      rptr_q <= '0;
      cnt_q <= '0;
    end else begin
      if (push) begin
        wptr_q <= (wptr_q == AW'(DEPTH - 1)) ? '0 : wptr_q + 1'b1;
      end
      if (pop) begin
        rptr_q <= (rptr_q == AW'(DEPTH - 1)) ? '0 : rptr_q + 1'b1;
      end
      cnt_q <= cnt_q + (AW+1)'(push) - (AW+1)'(pop);
    end
  end
endmodule : pbc_fifo

// File: src/pbc_burst_codec.sv
// ternary burst codec: read bursts encoded to beats, write beats decoded
// Operation
// (RULE_01) each eleven-bit group is coded into a fourteen-bit word, both least significant first.
// (RULE_02) the fourteen-bit word is seven two-bit symbol codes, each one line level.
// (RULE_03) one burst is 176 symbols, sixteen beats on eleven lanes.
// (RULE_04) a burst holds 23 eleven-bit coders numbered in placement order.
// (RULE_05) leftover data uses the three-bit code, severity and poison the one-symbol code.
// (RULE_06) bits and symbols go in ascending index order, least significant first.
// (RULE_07) 0x025 codes to 0x510 and 0x125 to 0x1110, and back.
// (RULE_08) 0x040 codes to 0x4c7 and 0x140 to 0x10c7, and back.
// (RULE_09) 0x0fc codes to 0x7ff and 0x1fc to 0x13ff, and back.
// (RULE_10) 0x0ff codes to 0x07c and 0x1ff to 0x13c, and back.
// (RULE_11) 0x027 codes to 0x40d and 0x127 to 0x100d, and back.
// (RULE_12) a burst is 23 eleven-bit codes, one data and six check three-bit codes, one flag symbol.
// (RULE_13) read data is encoded before sending and write data decoded before storing.
// (RULE_14) severity set makes the flag symbol ignore poison; writes carry no severity.
// (RULE_15) the decoder restores every value that the encoder produces.
// (RULE_16) the mappings are combinational; registers around them do not alter them.
`timescale 1ns/100ps
module pbc_burst_codec
  import pbc_pkg::*;
#(
  parameter int FIFO_DEPTH = FIFO_WORDS
) (
  // clock, reset, enable
  input wire logic clk,
  input wire logic rstn,
  input wire logic ce,
  // read burst from the array
  input wire logic rd_valid,
  output logic rd_ready,
  input wire logic [DATA_W-1:0] rd_data,
  input wire logic [CRC_W-1:0] rd_crc,
  input wire logic rd_sev,
  input wire logic rd_psn,
  // transmit beats
  output logic tx_valid,
  input wire logic tx_ready,
  output logic [BEAT_W-1:0] tx_beat,
  output logic tx_last,
  // received write beats
  input wire logic rx_valid,
  input wire logic rx_first,
  input wire logic [BEAT_W-1:0] rx_beat,
  // decoded write burst
  output logic wr_valid,
  output logic [DATA_W-1:0] wr_data,
  output logic [CRC_W-1:0] wr_crc,
  output logic wr_psn,
  output logic wr_sym_err
);
  typedef enum logic {S_IDLE, S_SEND} pbc_tx_state_t;

  // one symbol code per ternary digit
  function automatic logic [1:0] dig2sym(input logic [1:0] d);
    return (d == 2'd0) ? SYM_NEG : ((d == 2'd1) ? SYM_ZERO : SYM_POS);
  endfunction : dig2sym

  function automatic logic [1:0] sym2dig(input logic [1:0] s);
    return (s == SYM_POS) ? 2'd2 : ((s == SYM_ZERO) ? 2'd1 : 2'd0);
  endfunction : sym2dig

  // seven digits, least significant symbol in the low bits
  function automatic logic [13:0] tern7(input logic [11:0] v);
    logic [11:0] r;
    logic [13:0] c;
    r = v;
    c = '0;
    for (int i = 0; i < 7; i++) begin
      c[2*i +: 2] = dig2sym(2'(r % 12'd3)); // RULE_02
      r = r / 12'd3;
    end
    return c;
  endfunction : tern7

  // eleven bits to seven symbols
  function automatic logic [13:0] enc11(input logic [10:0] x);
    logic [11:0] v;
    logic [13:0] c;
    v = {1'b0, x};
    for (int k = 0; k < NPAIR; k++) begin
      if (x == PAIR_ALT[k][10:0]) v = SPARE_BASE + 12'(k);
    end
    c = tern7(v); // RULE_01
    for (int k = 0; k < NPAIR; k++) begin
      if (x == PAIR_IN[k]) c = PAIR_OUT[k]; // RULE_07 RULE_08 RULE_09 RULE_10 RULE_11
    end
    return c;
  endfunction : enc11

  // seven symbols back to eleven bits, error flag on top
  function automatic logic [11:0] dec11(input logic [13:0] c);
    logic [11:0] v;
    logic [10:0] r;
    logic e;
    v = '0;
    e = 1'b0;
    for (int i = 6; i >= 0; i--) begin
      e = e | (c[2*i +: 2] == SYM_BAD);
      v = 12'(v * 12'd3) + {10'd0, sym2dig(c[2*i +: 2])};
    end
    e = e | (v >= SPARE_END);
    r = v[10:0];
    for (int k = 0; k < NPAIR; k++) begin
      if (v == SPARE_BASE + 12'(k)) r = PAIR_ALT[k][10:0]; // RULE_15
    end
    for (int k = 0; k < NPAIR; k++) begin
      if (c == PAIR_OUT[k]) r = PAIR_IN[k]; // RULE_15
    end
    return {e, r};
  endfunction : dec11

  // three bits to two symbols, the all-zero-level pair left out
  function automatic logic [3:0] enc3(input logic [2:0] b);
    logic [3:0] v;
    v = (b < 3'd4) ? {1'b0, b} : {1'b0, b} + 4'd1;
    return {dig2sym(2'(v / 4'd3)), dig2sym(2'(v % 4'd3))};
  endfunction : enc3

  function automatic logic [3:0] dec3(input logic [3:0] c);
    logic [3:0] v;
    logic e;
    v = 4'({2'd0, sym2dig(c[3:2])} * 4'd3) + {2'd0, sym2dig(c[1:0])};
    e = (c[3:2] == SYM_BAD) || (c[1:0] == SYM_BAD) || (v == 4'd4);
    return {e, (v > 4'd4) ? 3'(v - 4'd1) : v[2:0]};
  endfunction : dec3

  // whole read burst, symbol s sits at lane s%11 of beat s/11
  function automatic logic [BURST_W-1:0] pack(input logic [DATA_W-1:0] d,
      input logic [CRC_W-1:0] crc, input logic severity_flag, input logic poison_flag);
    logic [BURST_W-1:0] f;
    f = '0;
    for (int e = 0; e < NENC; e++) begin
      f[e*CODE_W +: CODE_W] = enc11(d[e*DIN_W +: DIN_W]); // RULE_04
    end
    f[2*REM_POS +: 4] = enc3(d[DATA_W-1 -: 3]); // RULE_05
    for (int k = 0; k < NCRC3; k++) begin
      f[2*CRC_POS + 4*k +: 4] = enc3(crc[3*k +: 3]); // RULE_12
    end
    f[2*SP_POS +: 2] = severity_flag ? SYM_NEG : (poison_flag ? SYM_ZERO : SYM_POS); // RULE_14
    return f;
  endfunction : pack

  // whole write burst: {error, poison, check bits, data}
  function automatic logic [DATA_W+CRC_W+1:0] unpack(input logic [BURST_W-1:0] f);
    logic [DATA_W-1:0] d;
    logic [CRC_W-1:0] crc;
    logic [11:0] w;
    logic [3:0] t;
    logic e;
    e = 1'b0;
    for (int k = 0; k < NENC; k++) begin
      w = dec11(f[k*CODE_W +: CODE_W]); // RULE_04
      d[k*DIN_W +: DIN_W] = w[10:0];
      e = e | w[11];
    end
    t = dec3(f[2*REM_POS +: 4]); // RULE_05
    d[DATA_W-1 -: 3] = t[2:0];
    e = e | t[3];
    for (int k = 0; k < NCRC3; k++) begin
      t = dec3(f[2*CRC_POS + 4*k +: 4]); // RULE_12
      crc[3*k +: 3] = t[2:0];
      e = e | t[3];
    end
    // a write never carries severity, so only zero and high are legal
    e = e | (f[2*SP_POS +: 2] != SYM_ZERO && f[2*SP_POS +: 2] != SYM_POS); // RULE_14
    return {e, f[2*SP_POS +: 2] == SYM_ZERO, crc, d};
  endfunction : unpack

  pbc_tx_state_t state_q;
  logic [BURST_W-1:0] enc_q;
  logic [3:0] bcnt_q;
  logic [BURST_W-1:0] rbuf_q;
  logic [3:0] rcnt_q;
  logic rdone_q;
  logic wr_valid_q;
  logic [DATA_W-1:0] wr_data_q;
  logic [CRC_W-1:0] wr_crc_q;
  logic wr_psn_q;
  logic wr_err_q;

  // read side handshake and beat selection
  wire rd_fire = rd_valid && rd_ready && ce;
  wire fifo_in_ready;
  wire fifo_in_valid = (state_q == S_SEND);
  wire push = fifo_in_valid && fifo_in_ready && ce;
  wire [BURST_W-1:0] enc_w = pack(rd_data, rd_crc, rd_sev, rd_psn); // RULE_13 RULE_16
  wire [BEAT_W:0] fifo_in_data = {bcnt_q == LAST_BEAT, enc_q[bcnt_q*BEAT_W +: BEAT_W]};
  assign rd_ready = (state_q == S_IDLE);

  // write side beat placement and decode
  wire [3:0] widx = rx_first ? 4'd0 : rcnt_q;
  wire [DATA_W+CRC_W+1:0] dec_w = unpack(rbuf_q); // RULE_13 RULE_16

  // sender state
  always_ff @(posedge clk) begin
    if (!rstn) begin
      state_q <= S_IDLE;
    end else if (ce) begin
      case (state_q)
        S_IDLE: if (rd_valid) state_q <= S_SEND;
        S_SEND: if (fifo_in_ready && bcnt_q == LAST_BEAT) state_q <= S_IDLE; // RULE_03
        default: state_q <= S_IDLE;
      endcase
    end
  end

  // burst capture and beat counter, beat 0 first
  always_ff @(posedge clk) begin
    if (!rstn) begin
      enc_q <= '0;
      bcnt_q <= '0;
    end else if (rd_fire) begin
      enc_q <= enc_w;
      bcnt_q <= '0;
    end else if (push) begin
      bcnt_q <= bcnt_q + 4'd1; // RULE_06
    end
  end

  // receive beats into the burst buffer
  always_ff @(posedge clk) begin
    if (!rstn) begin
      rbuf_q <= '0;
      rcnt_q <= '0;
      rdone_q <= 1'b0;
    end else if (ce) begin
      if (rx_valid) begin
        rbuf_q[widx*BEAT_W +: BEAT_W] <= rx_beat; // RULE_06
        rcnt_q <= widx + 4'd1;
      end
      rdone_q <= rx_valid && (widx == LAST_BEAT); // RULE_03
    end
  end

  // decoded write burst registers
  always_ff @(posedge clk) begin
    if (!rstn) begin
      wr_valid_q <= 1'b0;
      wr_data_q <= '0;
      wr_crc_q <= '0;
      wr_psn_q <= 1'b0;
      wr_err_q <= 1'b0;
    end else if (ce) begin
      wr_valid_q <= rdone_q;
      if (rdone_q) begin
        {wr_err_q, wr_psn_q, wr_crc_q, wr_data_q} <= dec_w; // RULE_13
      end
    end
  end

  assign wr_valid = wr_valid_q;
  assign wr_data = wr_data_q;
  assign wr_crc = wr_crc_q;
  assign wr_psn = wr_psn_q;
  assign wr_sym_err = wr_err_q;

  // beat fifo between the encoder and the lanes
  pbc_fifo #(.WIDTH(BEAT_W + 1), .DEPTH(FIFO_DEPTH)) u_fifo (
    .clk(clk),
    .rstn(rstn),
    .ce(ce),
    .in_valid(fifo_in_valid),
    .in_ready(fifo_in_ready),
    .in_data(fifo_in_data),
    .out_valid(tx_valid),
    .out_ready(tx_ready),
    .out_data({tx_last, tx_beat})
  );

  // checks on the codec
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);

  property p_pair025;
    rd_fire && rd_data[10:0] == PAIR_IN[0] |=> enc_q[13:0] == PAIR_OUT[0];
  endproperty
  a_pair025: assert property (p_pair025) else $error("0x025 miscoded"); // RULE_07

  property p_pair140;
    rd_fire && rd_data[21:11] == PAIR_IN[3] |=> enc_q[27:14] == PAIR_OUT[3];
  endproperty
  a_pair140: assert property (p_pair140) else $error("0x140 miscoded"); // RULE_08

  property p_pair0fc;
    rd_fire && rd_data[10:0] == PAIR_IN[4] |=> enc_q[13:0] == PAIR_OUT[4];
  endproperty
  a_pair0fc: assert property (p_pair0fc) else $error("0x0fc miscoded"); // RULE_09

  property p_pair1ff;
    rd_fire && rd_data[10:0] == PAIR_IN[7] |=> enc_q[13:0] == PAIR_OUT[7];
  endproperty
  a_pair1ff: assert property (p_pair1ff) else $error("0x1ff miscoded"); // RULE_10

  property p_pair027;
    rd_fire && rd_data[10:0] == PAIR_IN[8] |=> enc_q[13:0] == PAIR_OUT[8];
  endproperty
  a_pair027: assert property (p_pair027) else $error("0x027 miscoded"); // RULE_11

  property p_inverse;
    rd_fire |-> dec11(enc11(rd_data[10:0])) == {1'b0, rd_data[10:0]};
  endproperty
  a_inverse: assert property (p_inverse) else $error("decode not inverse"); // RULE_15

  property p_sev;
    rd_fire && rd_sev |=> enc_q[2*SP_POS +: 2] == SYM_NEG;
  endproperty
  a_sev: assert property (p_sev) else $error("severity symbol wrong"); // RULE_14

  property p_rem;
    rd_fire |=> enc_q[2*REM_POS +: 4] == enc3($past(rd_data[DATA_W-1 -: 3]));
  endproperty
  a_rem: assert property (p_rem) else $error("remainder symbols wrong"); // RULE_05

  property p_end16;
    push && bcnt_q == LAST_BEAT |=> state_q == S_IDLE && rd_ready;
  endproperty
  a_end16: assert property (p_end16) else $error("burst not ended at beat 16"); // RULE_03

  property p_wr;
    rdone_q && ce |=> wr_valid && wr_data == $past(dec_w[DATA_W-1:0]);
  endproperty
  a_wr: assert property (p_wr) else $error("write burst not delivered"); // RULE_13
endmodule : pbc_burst_codec

// File: test/pbc_host_model.sv
// host-side partner: sinks transmit beats and sends write beats
`timescale 1ns/100ps
module pbc_host_model
  import pbc_pkg::*;
(
  // clock, reset and enable
  input wire logic clk,
  input wire logic rstn,
  input wire logic ce,
  // beat sink
  input wire logic stall,
  input wire logic tx_valid,
  output logic tx_ready,
  input wire logic [BEAT_W-1:0] tx_beat,
  input wire logic tx_last,
  output logic got,
  output logic last_ok,
  output logic [BURST_W-1:0] got_burst,
  // beat source
  input wire logic go,
  input wire logic [BURST_W-1:0] snd,
  output logic busy,
  output logic rx_valid,
  output logic rx_first,
  output logic [BEAT_W-1:0] rx_beat
);
  logic [15:0] sr = 16'h7316;
  int ti = 0;
  int ri = 0;
  // collect a burst; the end marker must flag only the sixteenth beat
  always @(posedge clk) begin
    got <= 1'b0;
    if (!rstn) begin
      ti <= 0;
    end else if (ce && tx_valid && tx_ready) begin
      got_burst[BEAT_W*ti +: BEAT_W] <= tx_beat;
      last_ok <= (ti == 0 || last_ok) && (tx_last === (ti == BEATS-1));
      got <= (ti == BEATS-1);
      ti <= (ti + 1) % BEATS;
    end
  end
  // pace ready and write beats; lines between beats carry inverted data
  always @(negedge clk) begin
    sr <= {sr[14:0], sr[15] ^ sr[13] ^ sr[12] ^ sr[10]};
    tx_ready <= rstn && !stall && (sr[0] || sr[1]);
    rx_valid <= 1'b0;
    rx_first <= 1'b0;
    rx_beat <= ~rx_beat;
    if (!rstn) begin
      busy <= 1'b0;
      rx_beat <= '0;
    end else if (go && !busy) begin
      busy <= 1'b1;
      ri <= 0;
    end else if (busy && sr[2]) begin
      rx_valid <= 1'b1;
      rx_first <= (ri == 0);
      rx_beat <= snd[BEAT_W*ri +: BEAT_W];
      ri <= ri + 1;
      busy <= (ri != BEATS-1);
    end
  end
endmodule : pbc_host_model

// File: test/pbc_burst_codec_tb.sv
// self-checking bench for the ternary burst codec
`timescale 1ns/100ps
module pbc_burst_codec_tb;
  import pbc_pkg::*;
  logic clk = 0, rstn = 0, ce = 1, rd_valid = 0, rd_sev = 0, rd_psn = 0;
  logic stall = 0, go = 0, rd_ready, tx_valid, tx_ready, tx_last, rx_valid, rx_first;
  logic wr_valid, wr_psn, wr_sym_err, got, last_ok, busy;
  logic [DATA_W-1:0] rd_data = '0, wr_data, d = '0;
  logic [CRC_W-1:0] rd_crc = '0, wr_crc;
  logic [BEAT_W-1:0] tx_beat, rx_beat;
  logic [BURST_W-1:0] snd = '0, got_burst, b;
  logic [BURST_W-1:0] exp_q[$];
  logic [31:0] seed = 32'h7316_118b;
  int error_cnt = 0;
  int check_count = 0;
  // 200 MHz clock
  always #2.5 clk = ~clk;
  pbc_burst_codec #(.FIFO_DEPTH(FIFO_WORDS)) pbc_burst_codec_inst (.clk, .rstn, .ce,
    .rd_valid, .rd_ready, .rd_data, .rd_crc, .rd_sev, .rd_psn, .tx_valid, .tx_ready,
    .tx_beat, .tx_last, .rx_valid, .rx_first, .rx_beat, .wr_valid, .wr_data, .wr_crc,
    .wr_psn, .wr_sym_err);
  pbc_host_model pbc_host_model_inst (.clk, .rstn, .ce, .stall, .tx_valid, .tx_ready,
    .tx_beat, .tx_last, .got, .last_ok, .got_burst, .go, .snd(snd), .busy, .rx_valid,
    .rx_first, .rx_beat);
  function automatic logic [31:0] rnd();
    seed = {seed[30:0], seed[31] ^ seed[21] ^ seed[1] ^ seed[0]};
    return seed;
  endfunction : rnd
  // base-3 digits, least significant symbol first
  function automatic logic [13:0] tern(input int v);
    logic [13:0] c;
    for (int i = 0; i < 7; i++) begin
      c[2*i +: 2] = (v % 3 == 2) ? SYM_POS : ((v % 3 == 1) ? SYM_ZERO : SYM_NEG);
      v = v / 3;
    end
    return c;
  endfunction : tern
  function automatic logic [13:0] enc11(input logic [10:0] v);
    for (int k = 0; k < NPAIR; k++) begin
      if (v == PAIR_IN[k]) return PAIR_OUT[k];
      if ({1'b0, v} == PAIR_ALT[k]) return tern(2048 + k);
    end
    return tern(int'(v));
  endfunction : enc11
  // expected burst of 176 symbols in flat placement order
  function automatic logic [BURST_W-1:0] mk(input logic [DATA_W-1:0] dd,
      input logic [CRC_W-1:0] c, input logic s, input logic p);
    logic [BURST_W-1:0] r;
    r = '0;
    for (int e = 0; e < NENC; e++) r[14*e +: 14] = enc11(dd[11*e +: 11]);
    r[2*REM_POS +: 4] = 4'(tern(int'(dd[255:253]) + int'(dd[255:253] > 3'h3)));
    for (int k = 0; k < NCRC3; k++)
      r[2*(CRC_POS+2*k) +: 4] = 4'(tern(int'(c[3*k +: 3]) + int'(c[3*k +: 3] > 3'h3)));
    r[2*SP_POS +: 2] = s ? SYM_NEG : (p ? SYM_ZERO : SYM_POS);
    return r;
  endfunction : mk
  task automatic chk(input string nm, input logic [BURST_W-1:0] e, input logic [BURST_W-1:0] g);
    check_count++;
    if (g !== e) begin
      error_cnt++;
      $display("mismatch %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  task automatic summarize();
    $display("checks %0d mismatches %0d", check_count, error_cnt);
    if (error_cnt == 0 && check_count > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : summarize
  task automatic wait_hi(ref logic s, input string nm);
    int n;
    n = 0;
    while (s !== 1'b1) begin
      @(negedge clk);
      n++;
      if (n > 400) begin
        error_cnt++;
        $display("mismatch %s expected 1 seen timeout", nm);
        summarize();
      end
    end
  endtask : wait_hi
  task automatic rd_send(input logic [DATA_W-1:0] dd, input logic [CRC_W-1:0] c,
      input logic s, input logic p);
    @(negedge clk);
    wait_hi(rd_ready, "rd_ready");
    rd_data <= dd;
    rd_crc <= c;
    rd_sev <= s;
    rd_psn <= p;
    rd_valid <= 1'b1;
    exp_q.push_back(mk(dd, c, s, p));
    @(negedge clk);
    rd_valid <= 1'b0;
  endtask : rd_send
  task automatic drain();
    for (int i = 0; i < 900 && exp_q.size() > 0; i++) @(negedge clk);
    chk("bursts left", 0, exp_q.size());
    if (exp_q.size() > 0) summarize();
  endtask : drain
  task automatic wr_chk(input logic [BURST_W-1:0] w, input logic p, input logic err);
    @(negedge clk);
    snd <= w;
    go <= 1'b1;
    @(negedge clk);
    go <= 1'b0;
    wait_hi(wr_valid, "wr_valid");
    chk("wr_sym_err", err, wr_sym_err);
    if (!err) begin
      chk("wr_data", d, wr_data);
      chk("wr_crc", rd_crc, wr_crc);
      chk("wr_psn", p, wr_psn);
    end
    @(negedge clk);
    chk("wr_valid pulse", 0, wr_valid);
  endtask : wr_chk
  // compare every burst the partner collects
  always @(negedge clk) begin
    if (got === 1'b1) begin
      if (exp_q.size() == 0) chk("extra burst", 0, 1);
      else chk("tx burst", exp_q.pop_front(), got_burst);
      chk("tx_last", 1, last_ok);
    end
  end
  // main sequence
  initial begin
    repeat (8) @(negedge clk);
    chk("rd_ready reset", 1, rd_ready);
    chk("tx_valid reset", 0, tx_valid);
    chk("wr_valid reset", 0, wr_valid);
    rstn <= 1'b1;
    // rotate the fixed table entries so every coder slot meets every entry
    for (int r = 0; r < NPAIR; r++) begin
      for (int e = 0; e < NENC; e++) d[11*e +: 11] = PAIR_IN[(e + r) % NPAIR];
      rd_send(d, 18'h3_ffff, 1'b1, r[0]);
    end
    for (int e = 0; e < NENC; e++) d[11*e +: 11] = PAIR_ALT[e % NPAIR][10:0];
    rd_send(d, 18'h0_0000, 1'b0, 1'b1);
    rd_send('1, 18'h2_c688, 1'b0, 1'b0);
    for (int t = 0; t < 6; t++) rd_send({8{rnd()}}, 18'(rnd()), rnd() > 32'h8000_0000, seed[3]);
    drain();
    $display("test read bursts done");
    stall <= 1'b1;
    repeat (3) rd_send({8{rnd()}}, 18'(rnd()), 1'b0, seed[5]);
    repeat (20) @(negedge clk);
    chk("rd_ready full", 0, rd_ready);
    chk("tx_valid full", 1, tx_valid);
    ce <= 1'b0;
    stall <= 1'b0;
    repeat (6) @(negedge clk);
    chk("frozen bursts", 3, exp_q.size());
    ce <= 1'b1;
    drain();
    chk("tx_valid empty", 0, tx_valid);
    $display("test fifo fill done");
    for (int e = 0; e < NENC; e++) d[11*e +: 11] = PAIR_IN[(e + 3) % NPAIR];
    rd_crc <= 18'h1_55aa;
    @(negedge clk);
    wr_chk(mk(d, rd_crc, 1'b0, 1'b1), 1'b1, 1'b0);
    for (int t = 0; t < 5; t++) begin
      d = {8{rnd()}};
      rd_crc <= 18'(rnd());
      @(negedge clk);
      wr_chk(mk(d, rd_crc, 1'b0, seed[7]), seed[7], 1'b0);
    end
    b = mk(d, rd_crc, 1'b0, 1'b0);
    b[1:0] = SYM_BAD;
    wr_chk(b, 1'b0, 1'b1);
    wr_chk(mk(d, rd_crc, 1'b1, 1'b0), 1'b0, 1'b1);
    $display("test write bursts done");
    summarize();
  end
endmodule : pbc_burst_codec_tb
